// File: cqh_pkg.sv
/*
 * constants and carriers for the quarter-hour performance counter.
 * assumes one per-second count strobe per delayed second and a one-cycle
 * quarter-hour tick, both synchronous to clk_sys.
 */
`default_nettype none

package cqh_pkg;

    // capacities for the 1 Gb/s multiplex layer
    localparam int unsigned CQH_CAP_ERRORED_SECOND = 900;
    localparam int unsigned CQH_CAP_BACKGROUND_BLOCK_ERROR = 2160000;
    localparam int unsigned CQH_CAP_SEVERELY_ERRORED_SECOND = 810;
    localparam int unsigned CQH_CAP_UNAVAILABLE_SECOND = 900;

    // widest capacity sets the carrier width
    localparam int unsigned CQH_TOTAL_W = $clog2(CQH_CAP_BACKGROUND_BLOCK_ERROR + 1);
    localparam int unsigned CQH_COUNT_W = CQH_TOTAL_W;

    // nominal interval length in seconds
    localparam int unsigned CQH_INTERVAL_SECONDS = 900;

    localparam logic [CQH_TOTAL_W-1:0] CQH_TOTAL_RESET = 22'h000000;

    typedef enum {
        CQH_ERRORED_SECOND,
        CQH_BACKGROUND_BLOCK_ERROR,
        CQH_SEVERELY_ERRORED_SECOND,
        CQH_UNAVAILABLE_SECOND
    } cqh_parameter_type;

    typedef logic [CQH_TOTAL_W-1:0] cqh_total_type;

    // per-second input from the availability filter
    typedef struct packed {
        logic second_strobe;
        logic [CQH_COUNT_W-1:0] per_second_count_in;
    } cqh_count_type;

    // completed interval handed to history storage
    typedef struct packed {
        logic valid;
        logic saturated;
        cqh_total_type total;
    } cqh_transfer_type;

    // capacity of the running total for one monitored parameter
    function automatic cqh_total_type cqh_capacity(input cqh_parameter_type kind);
        case (kind)
            CQH_ERRORED_SECOND: cqh_capacity = cqh_total_type'(CQH_CAP_ERRORED_SECOND);
            CQH_BACKGROUND_BLOCK_ERROR: begin
                cqh_capacity = cqh_total_type'(CQH_CAP_BACKGROUND_BLOCK_ERROR);
            end
            CQH_SEVERELY_ERRORED_SECOND: begin
                cqh_capacity = cqh_total_type'(CQH_CAP_SEVERELY_ERRORED_SECOND);
            end
            CQH_UNAVAILABLE_SECOND: cqh_capacity = cqh_total_type'(CQH_CAP_UNAVAILABLE_SECOND);
            default: cqh_capacity = cqh_total_type'(CQH_CAP_BACKGROUND_BLOCK_ERROR);
        endcase
    endfunction

endpackage

`default_nettype wire

// File: cqh_counter.sv
/*
 * current quarter-hour register: saturating accumulator for one
 * performance-monitoring parameter, with hand-off at each interval end.
 * assumes an upstream availability filter giving one count per delayed
 * second, and a time base giving a one-cycle quarter-hour tick.
 */
// What this block does
// - add every per-second count into the running quarter-hour total
// - total register holds every integer from zero to its maximum
// - maximum is no smaller than the nominal count of one interval, except SEVERELY_ERRORED_SECOND_COUNT at 810
// - at maximum the total saturates and holds until cleared or transferred
// - 1 Gb/s capacities: 900 ES and UNAVAILABLE_SECOND_COUNT, 2 160 000 BBE, 810 SEVERELY_ERRORED_SECOND_COUNT
`default_nettype none

module cqh_counter #(
    parameter cqh_pkg::cqh_parameter_type MONITORED = cqh_pkg::CQH_BACKGROUND_BLOCK_ERROR
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // per-second input and interval tick
    input wire cqh_pkg::cqh_count_type count_in,
    input wire logic quarter_hour_tick,
    // running state
    output cqh_pkg::cqh_total_type running_quarter_total,
    output logic total_saturated,
    // completed interval
    output cqh_pkg::cqh_transfer_type transfer_out
);

    // capacity fixed by the monitored parameter
    localparam cqh_pkg::cqh_total_type MAX_TOTAL = cqh_pkg::cqh_capacity(MONITORED);

    // reset level of the one-bit flags
    localparam logic FLAG_RESET = 1'b0;

    // one spare bit so the sum cannot wrap
    localparam int unsigned WIDE_W = cqh_pkg::CQH_TOTAL_W + 1;

    typedef logic [WIDE_W-1:0] cqh_wide_type;

    // running total group
    cqh_pkg::cqh_total_type total_reg;
    cqh_pkg::cqh_total_type total_next;

    // saturation indication group
    logic saturated_reg;
    logic saturated_next;

    // hand-off valid pulse group
    logic valid_reg;
    logic valid_next;

    // hand-off saturation group
    logic held_saturated_reg;
    logic held_saturated_next;

    // hand-off total group
    cqh_pkg::cqh_total_type held_total_reg;
    cqh_pkg::cqh_total_type held_total_next;

    // qualified increment, interval end and start value
    logic [cqh_pkg::CQH_COUNT_W-1:0] increment;
    logic interval_end;
    cqh_pkg::cqh_total_type start_value;
    cqh_pkg::cqh_transfer_type transfer_value;

    // total has reached the capacity of this parameter
    function automatic logic at_capacity(
        input cqh_pkg::cqh_total_type value
    );
        at_capacity = (value == MAX_TOTAL);
    endfunction

    // widen a total without changing its value
    function automatic cqh_wide_type widen(
        input cqh_pkg::cqh_total_type value
    );
        widen = {1'b0, value};
    endfunction

    // saturating add onto a base value
    function automatic cqh_pkg::cqh_total_type sat_add(
        input cqh_pkg::cqh_total_type base,
        input logic [cqh_pkg::CQH_COUNT_W-1:0] inc
    );
        cqh_wide_type sum;
        cqh_wide_type limit;
        logic over;

        sum = widen(base) + widen(inc);
        limit = widen(MAX_TOTAL);
        over = (sum >= limit);

        if (over) begin
            sat_add = MAX_TOTAL;
        end else begin
            sat_add = sum[cqh_pkg::CQH_TOTAL_W-1:0];
        end
    endfunction

    // per-second count only counts when its strobe is up
    always_comb begin
        increment = '0;

        if (count_in.second_strobe) begin
            increment = count_in.per_second_count_in;
        end
    end

    // tick closes the interval this cycle
    assign interval_end = quarter_hour_tick;

    // accumulation restarts from zero on the tick
    always_comb begin
        start_value = total_reg;

        if (interval_end) begin
            start_value = cqh_pkg::CQH_TOTAL_RESET;
        end
    end

    // running total next value
    always_comb begin
        total_next = sat_add(start_value, increment);
    end

    // running total register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            total_reg <= cqh_pkg::CQH_TOTAL_RESET;
        end else begin
            total_reg <= total_next;
        end
    end

    // saturation indication next value
    always_comb begin
        saturated_next = at_capacity(total_next);
    end

    // saturation indication register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            saturated_reg <= FLAG_RESET;
        end else begin
            saturated_reg <= saturated_next;
        end
    end

    // hand-off valid pulse next value
    always_comb begin
        valid_next = 1'b0;

        if (interval_end) begin
            valid_next = 1'b1;
        end
    end

    // hand-off valid pulse register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            valid_reg <= FLAG_RESET;
        end else begin
            valid_reg <= valid_next;
        end
    end

    // hand-off saturation next value
    always_comb begin
        held_saturated_next = held_saturated_reg;

        if (interval_end) begin
            held_saturated_next = saturated_reg;
        end
    end

    // hand-off saturation register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            held_saturated_reg <= FLAG_RESET;
        end else begin
            held_saturated_reg <= held_saturated_next;
        end
    end

    // hand-off total next value
    always_comb begin
        held_total_next = held_total_reg;

        if (interval_end) begin
            held_total_next = total_reg;
        end
    end

    // hand-off total register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            held_total_reg <= cqh_pkg::CQH_TOTAL_RESET;
        end else begin
            held_total_reg <= held_total_next;
        end
    end

    // completed interval assembled from its registers
    always_comb begin
        transfer_value.valid = valid_reg;
        transfer_value.saturated = held_saturated_reg;
        transfer_value.total = held_total_reg;
    end

    // outputs straight from the registers
    assign running_quarter_total = total_reg;
    assign total_saturated = saturated_reg;
    assign transfer_out = transfer_value;

endmodule

`default_nettype wire

// File: cqh_counter_chk.sv
/* checker on cqh_counter ports; assumes one clock, async reset high */
`default_nettype none
module cqh_chk #(parameter int unsigned CAP = 2160000) (
    input wire logic clk_sys, reset, quarter_hour_tick, total_saturated,
    input wire cqh_pkg::cqh_count_type count_in,
    input wire cqh_pkg::cqh_total_type running_quarter_total,
    input wire cqh_pkg::cqh_transfer_type transfer_out);
    wire logic [23:0] t = 24'(running_quarter_total);
    wire logic [23:0] u = t + 24'(count_in.per_second_count_in);
    wire logic s = count_in.second_strobe;
    wire logic k = quarter_hour_tick;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_add_count: assert property (s && !k && u < CAP |=> t == $past(u)) else $error("add");
    a_clamp_max: assert property (s && !k && u >= CAP |=> t == CAP) else $error("cap");
    a_hold_max: assert property (t == CAP && !k |=> t == CAP) else $error("hold");
    a_sat_flag: assert property (total_saturated == (t == CAP)) else $error("flag");
    a_hand_off: assert property (k |=> transfer_out.total == $past(t)) else $error("xfer");
    a_zero_start: assert property (k && !s |=> t == 0) else $error("zero");
    a_valid_pulse: assert property (k |=> transfer_out.valid) else $error("pulse");
    a_valid_idle: assert property (!k |=> !transfer_out.valid) else $error("idle");
    c_both: cover property (k && s);
    c_sat: cover property (total_saturated);
    c_xfer: cover property (transfer_out.valid && transfer_out.saturated);
endmodule
bind cqh_counter cqh_chk cqh_chk_i (.*);
`default_nettype wire

// File: cqh_src.sv
/* source model: per-second counts and tick; drives on falling clk_sys */
`default_nettype none
module cqh_src (input wire logic clk_sys, output logic quarter_hour_tick,
    output cqh_pkg::cqh_count_type count_in);
    timeunit 1ns / 1ns;
    initial {count_in, quarter_hour_tick} = '0;
    task automatic send(input logic s, input cqh_pkg::cqh_total_type c, input logic k);
        @(negedge clk_sys);
        count_in = '{s, s ? c : ~count_in.per_second_count_in};
        quarter_hour_tick = k;
    endtask
endmodule
`default_nettype wire

// File: cqh_counter_test.sv
/* bench: cqh_src feeds cqh_counter; results judged at the ports */
`default_nettype none
module cqh_counter_test;
    timeunit 1ns / 1ns;
    logic clk_sys = 1'b0, reset = 1'b1, quarter_hour_tick, total_saturated;
    int n_errors = 0, comparisons = 0;
    cqh_pkg::cqh_count_type count_in;
    cqh_pkg::cqh_total_type running_quarter_total;
    cqh_pkg::cqh_transfer_type transfer_out;
    always #50 clk_sys = ~clk_sys;
    cqh_src cqh_src_i (.*);
    cqh_counter cqh_counter_i (.*);
    task automatic chk(input string n, input cqh_pkg::cqh_total_type seen, exp);
        comparisons++;
        n_errors += int'(seen !== exp);
        if (seen !== exp) $display("BAD %s expected %h seen %h", n, exp, seen);
    endtask
    task automatic end_of_test(input int bad);
        n_errors += bad;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic t_interval();
        repeat (cqh_pkg::CQH_INTERVAL_SECONDS) cqh_src_i.send(1, 1, 0);
        cqh_src_i.send(0, 0, 1);
        cqh_src_i.send(0, 0, 0);
        chk("valid", transfer_out.valid, 22'h000001);
        chk("total", transfer_out.total, 22'h000384);
        chk("restart", running_quarter_total, 22'h000000);
        $display("interval done");
    endtask
    task automatic t_saturate();
        cqh_src_i.send(1, 22'h200000, 0);
        cqh_src_i.send(1, 22'h010000, 0);
        cqh_src_i.send(1, 1, 0);
        cqh_src_i.send(1, 5, 1);
        chk("clamp", running_quarter_total, 22'h20f580);
        chk("full", total_saturated, 22'h000001);
        cqh_src_i.send(0, 0, 0);
        chk("sat", transfer_out.saturated, 22'h000001);
        chk("new", running_quarter_total, 22'h000005);
        cqh_src_i.send(0, 0, 0);
        chk("pulse", transfer_out.valid, 22'h000000);
        chk("unfull", total_saturated, 22'h000000);
        $display("saturate done");
    endtask
    task automatic t_reset();
        cqh_src_i.send(1, 7, 0);
        cqh_src_i.send(0, 0, 0);
        chk("before", running_quarter_total, 22'h00000c);
        reset = 1'b1;
        #1;
        chk("cleared", running_quarter_total, 22'h000000);
        chk("held", transfer_out.total, 22'h000000);
        cqh_src_i.send(0, 0, 0);
        reset = 1'b0;
        cqh_src_i.send(1, 3, 0);
        cqh_src_i.send(0, 0, 0);
        chk("again", running_quarter_total, 22'h000003);
        $display("reset done");
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        t_interval();
        t_saturate();
        t_reset();
        end_of_test(0);
    end
    initial #300us end_of_test(1);
endmodule
`default_nettype wire
